//--- verilog/spe_pkg.sv
// Constants, types and helpers of the SPI EEPROM protect control block
package spe_pkg;

	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_SET_LATCH   = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
	localparam logic [7:0] OP_READ_ARRAY  = 8'h03;
	localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;

	// ==========================================================
	// Array geometry
	localparam int         ADDR_BITS  = 13;
	localparam int         PAGE_BYTES = 32;
	localparam int         PAGE_BITS  = 5;
	localparam int         MEM_BYTES  = 8192;
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [2:0] BIT_FIRST  = 3'h0;

	// ==========================================================
	// Status register fields and reset values
	localparam int         ST_PIN_EN  = 7;
	localparam int         ST_GUARD1  = 3;
	localparam int         ST_GUARD0  = 2;
	localparam logic [7:0] ST_BUSY_WORD = 8'hFF;
	localparam logic       PIN_EN_RST = 1'b0;
	localparam logic [1:0] GUARD_RST  = 2'h0;

	// ==========================================================
	// Guarded range starts
	localparam logic [12:0] GUARD_QUARTER = 13'h1800;
	localparam logic [12:0] GUARD_HALF    = 13'h1000;

	// ==========================================================
	// Write cycle timing
	localparam int WRITE_TIME_MS = 5;
	localparam int CLK_SYS_MHZ   = 40;
	localparam int WRITE_CYCLES  = WRITE_TIME_MS * CLK_SYS_MHZ * 1000;

	// ==========================================================
	// Types
	typedef enum logic [7:0] {
		PH_OP      = 8'h01,
		PH_ADDR_HI = 8'h02,
		PH_ADDR_LO = 8'h04,
		PH_RD_DATA = 8'h08,
		PH_WR_DATA = 8'h10,
		PH_STAT_RD = 8'h20,
		PH_STAT_WR = 8'h40,
		PH_IGNORE  = 8'h80
	} spe_phase_t;

	typedef enum logic [3:0] {
		ACT_SET   = 4'h1,
		ACT_CLR   = 4'h2,
		ACT_STAT  = 4'h4,
		ACT_ARRAY = 4'h8
	} spe_act_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'h1,
		ENG_BUSY = 2'h2
	} spe_eng_t;

	// Address falls inside the range selected by the guard bits
	function automatic logic isGuarded(logic [12:0] addr, logic [1:0] g);
		case (g)
			2'h1:    isGuarded = (addr >= GUARD_QUARTER);
			2'h2:    isGuarded = (addr >= GUARD_HALF);
			2'h3:    isGuarded = 1'b1;
			default: isGuarded = 1'b0;
		endcase
	endfunction

endpackage

//--- verilog/spe_eeprom_ctrl.sv
// Serial EEPROM command, status and write-protection control
`timescale 1ns/1ps
module spe_eeprom_ctrl #(
	parameter int WRITE_CYCLES = spe_pkg::WRITE_CYCLES
) (
	// System clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Serial link
	input  wire logic serialClk,
	input  wire logic chipSelN,
	input  wire logic serialIn,
	input  wire logic pauseN,
	input  wire logic writeProtN,
	output logic      serialOut,
	output logic      serialOutOe,
	// Status towards the system
	output logic      writeBusy
);

	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);

	// ==========================================================
	// Declarations
	spe_pkg::spe_phase_t phase_r;
	spe_pkg::spe_act_t   pendAct_r;
	spe_pkg::spe_eng_t   eng_r;
	logic [2:0]  bitCnt_r;
	logic [6:0]  shift_r;
	logic [7:0]  byteIn;
	logic        byteEnd;
	logic [12:0] addr_r;
	logic [12:0] addrInc;
	logic [7:0]  rdByte_r;
	logic        isRead_r;
	logic        pendValid_r;
	logic [7:0]  pendStat_r;
	logic [7:0]  pageBase_r;
	logic [31:0] pageMask_r;
	logic [7:0]  pageBuf_r [spe_pkg::PAGE_BYTES];
	logic [7:0]  mem_r [spe_pkg::MEM_BYTES];
	logic [8:0]  linkS1_r;
	logic [8:0]  linkS2_r;
	logic [8:0]  linkS3_r;
	logic [8:0]  linkHeld_r;
	logic [7:0]  statLink;
	logic        readyLink;
	logic [2:0]  sysS1_r;
	logic [2:0]  sysS2_r;
	logic [2:0]  sysS3_r;
	logic [2:0]  sysHeld_r;
	logic        csHeld;
	logic        wpHeld;
	logic        pendHeld;
	logic        csPrev_r;
	logic        csRise;
	logic        csFall;
	logic        commitReq_r;
	logic        selSeen_r;
	logic        wpAbort_r;
	logic        hwProt;
	logic        wel_r;
	logic        pinEn_r;
	logic [1:0]  guard_r;
	logic [CNT_W-1:0] timer_r;
	logic        commitOk;
	logic        startArray;
	logic [8:0]  statSys_r;

	// ==========================================================
	// Link domain: frame sequencing

	// Incoming byte and byte boundary
	assign byteIn  = {shift_r, serialIn};
	assign byteEnd = (bitCnt_r == spe_pkg::BIT_LAST);
	assign addrInc = addr_r + 13'h1;
	assign statLink  = linkHeld_r[7:0];
	assign readyLink = linkHeld_r[8];

	// Opcode, address and read data on rising clock edges
	always_ff @(posedge serialClk or posedge chipSelN) begin
		if (chipSelN) begin
			phase_r  <= spe_pkg::PH_OP;
			bitCnt_r <= spe_pkg::BIT_FIRST;
			shift_r  <= 7'h00;
			addr_r   <= 13'h0000;
			rdByte_r <= 8'h00;
			isRead_r <= 1'b0;
		end else if (pauseN) begin
			bitCnt_r <= bitCnt_r + 3'h1;
			shift_r  <= byteIn[6:0];
			if (byteEnd) begin
				case (phase_r)
					spe_pkg::PH_OP: begin
						case (byteIn)
							spe_pkg::OP_READ_STATUS: begin
								phase_r  <= spe_pkg::PH_STAT_RD;
								rdByte_r <= statLink;
							end
							spe_pkg::OP_WRITE_STAT:
								phase_r <= spe_pkg::PH_STAT_WR;
							spe_pkg::OP_READ_ARRAY: begin
								phase_r  <= spe_pkg::PH_ADDR_HI;
								isRead_r <= 1'b1;
							end
							spe_pkg::OP_WRITE_ARRAY:
								phase_r <= spe_pkg::PH_ADDR_HI;
							// Latch commands and unknown codes idle here
							default: phase_r <= spe_pkg::PH_IGNORE;
						endcase
					end
					spe_pkg::PH_ADDR_HI: begin
						addr_r[12:8] <= byteIn[4:0];
						phase_r      <= spe_pkg::PH_ADDR_LO;
					end
					spe_pkg::PH_ADDR_LO: begin
						addr_r[7:0] <= byteIn;
						if (isRead_r) begin
							phase_r  <= spe_pkg::PH_RD_DATA;
							rdByte_r <= mem_r[{addr_r[12:8], byteIn}];
						end else begin
							phase_r <= spe_pkg::PH_WR_DATA;
						end
					end
					spe_pkg::PH_RD_DATA: begin
						addr_r   <= addrInc;
						rdByte_r <= mem_r[addrInc];
					end
					spe_pkg::PH_WR_DATA:
						addr_r[4:0] <= addr_r[4:0] + 5'h01;
					spe_pkg::PH_STAT_RD:
						rdByte_r <= statLink;
					default: ;
				endcase
			end
		end
	end

	// Pending action and page buffer, kept across select high
	always_ff @(posedge serialClk or negedge resetn) begin
		if (!resetn) begin
			pendValid_r <= 1'b0;
			pendAct_r   <= spe_pkg::ACT_SET;
			pendStat_r  <= 8'h00;
			pageBase_r  <= 8'h00;
			pageMask_r  <= 32'h00000000;
		end else if (!chipSelN && pauseN) begin
			// Any further bit cancels a pending action
			pendValid_r <= 1'b0;
			if (phase_r == spe_pkg::PH_OP && bitCnt_r == spe_pkg::BIT_FIRST)
				pageMask_r <= 32'h00000000;
			if (byteEnd) begin
				case (phase_r)
					spe_pkg::PH_OP: begin
						if (byteIn == spe_pkg::OP_SET_LATCH) begin
							pendValid_r <= 1'b1;
							pendAct_r   <= spe_pkg::ACT_SET;
						end else if (byteIn == spe_pkg::OP_CLR_LATCH) begin
							pendValid_r <= 1'b1;
							pendAct_r   <= spe_pkg::ACT_CLR;
						end
					end
					spe_pkg::PH_WR_DATA: begin
						pendValid_r <= 1'b1;
						pendAct_r   <= spe_pkg::ACT_ARRAY;
						pageBase_r  <= addr_r[12:5];
						pageMask_r[addr_r[4:0]] <= 1'b1;
					end
					spe_pkg::PH_STAT_WR: begin
						pendValid_r <= 1'b1;
						pendAct_r   <= spe_pkg::ACT_STAT;
						pendStat_r  <= byteIn;
					end
					default: ;
				endcase
			end
		end
	end

	// Page data bytes, later bytes to the same slot overwrite
	always_ff @(posedge serialClk) begin
		if (!chipSelN && pauseN && byteEnd
		    && phase_r == spe_pkg::PH_WR_DATA)
			pageBuf_r[addr_r[4:0]] <= byteIn;
	end

	// Serial output changes on falling edges, MSB first
	always_ff @(negedge serialClk or posedge chipSelN) begin
		if (chipSelN) begin
			serialOut   <= 1'b0;
			serialOutOe <= 1'b0;
		end else if (pauseN) begin
			serialOut   <= rdByte_r[~bitCnt_r];
			serialOutOe <= readyLink
				&& (phase_r == spe_pkg::PH_RD_DATA
				|| phase_r == spe_pkg::PH_STAT_RD);
		end
	end

	// Status and ready word into the link domain
	always_ff @(posedge serialClk or negedge resetn) begin
		if (!resetn) begin
			linkS1_r   <= 9'h000;
			linkS2_r   <= 9'h000;
			linkS3_r   <= 9'h000;
			linkHeld_r <= 9'h000;
		end else begin
			linkS1_r   <= statSys_r;
			linkS2_r   <= linkS1_r;
			linkS3_r   <= linkS2_r;
			linkHeld_r <= (linkS2_r & linkS3_r)
				| (linkHeld_r & (linkS2_r | linkS3_r));
		end
	end

	// ==========================================================
	// System domain: pin capture and commit

	// Select, protect pin and pending flag, three stages each
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			// Select starts as if low so power-up needs a fall
			sysS1_r   <= 3'h2;
			sysS2_r   <= 3'h2;
			sysS3_r   <= 3'h2;
			sysHeld_r <= 3'h2;
		end else begin
			sysS1_r   <= {pendValid_r, writeProtN, chipSelN};
			sysS2_r   <= sysS1_r;
			sysS3_r   <= sysS2_r;
			sysHeld_r <= (sysS2_r & sysS3_r)
				| (sysHeld_r & (sysS2_r | sysS3_r));
		end
	end

	assign csHeld   = sysHeld_r[0];
	assign wpHeld   = sysHeld_r[1];
	assign pendHeld = sysHeld_r[2];
	assign csRise   = csHeld && !csPrev_r;
	assign csFall   = !csHeld && csPrev_r;
	assign hwProt   = !wpHeld && pinEn_r;

	// Select edges, first fall since reset, protect abort
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			csPrev_r    <= 1'b0;
			commitReq_r <= 1'b0;
			selSeen_r   <= 1'b0;
			wpAbort_r   <= 1'b0;
		end else begin
			csPrev_r    <= csHeld;
			commitReq_r <= csRise;
			if (csFall)
				selSeen_r <= 1'b1;
			if (!wpHeld && !csHeld && pinEn_r)
				wpAbort_r <= 1'b1;
			else if (csFall)
				wpAbort_r <= 1'b0;
		end
	end

	assign commitOk   = commitReq_r && pendHeld && selSeen_r
		&& eng_r == spe_pkg::ENG_IDLE;
	assign startArray = commitOk && wel_r
		&& pendAct_r == spe_pkg::ACT_ARRAY;

	// Latch, nonvolatile bits and self-timed write cycle
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			eng_r   <= spe_pkg::ENG_IDLE;
			timer_r <= '0;
			wel_r   <= 1'b0;
			pinEn_r <= spe_pkg::PIN_EN_RST;
			guard_r <= spe_pkg::GUARD_RST;
		end else begin
			case (eng_r)
				spe_pkg::ENG_IDLE: begin
					if (commitOk) begin
						case (pendAct_r)
							spe_pkg::ACT_SET: wel_r <= 1'b1;
							spe_pkg::ACT_CLR: wel_r <= 1'b0;
							spe_pkg::ACT_STAT: begin
								if (wel_r && !hwProt && !wpAbort_r) begin
									pinEn_r <= pendStat_r[spe_pkg::ST_PIN_EN];
									guard_r <= {pendStat_r[spe_pkg::ST_GUARD1],
										pendStat_r[spe_pkg::ST_GUARD0]};
									eng_r   <= spe_pkg::ENG_BUSY;
									timer_r <= CNT_LOAD;
								end
							end
							spe_pkg::ACT_ARRAY: begin
								if (wel_r) begin
									eng_r   <= spe_pkg::ENG_BUSY;
									timer_r <= CNT_LOAD;
								end
							end
							default: ;
						endcase
					end
				end
				spe_pkg::ENG_BUSY: begin
					if (timer_r == '0) begin
						eng_r <= spe_pkg::ENG_IDLE;
						wel_r <= 1'b0;
					end else begin
						timer_r <= timer_r - CNT_W'(1);
					end
				end
				default: eng_r <= spe_pkg::ENG_IDLE;
			endcase
		end
	end

	// Array update from the page buffer, guarded bytes skipped
	always_ff @(posedge clk_sys) begin
		if (startArray) begin
			for (int i = 0; i < spe_pkg::PAGE_BYTES; i++) begin
				if (pageMask_r[i] && !spe_pkg::isGuarded(
				    {pageBase_r, 5'(i)}, guard_r))
					mem_r[{pageBase_r, 5'(i)}] <= pageBuf_r[i];
			end
		end
	end

	// Status word seen by the link, and busy output
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			statSys_r <= 9'h000;
			writeBusy <= 1'b0;
		end else begin
			writeBusy <= (eng_r == spe_pkg::ENG_BUSY);
			if (eng_r == spe_pkg::ENG_BUSY)
				statSys_r <= {selSeen_r, spe_pkg::ST_BUSY_WORD};
			else
				statSys_r <= {selSeen_r, pinEn_r, 3'h0,
					guard_r, wel_r, 1'b0};
		end
	end

endmodule // spe_eeprom_ctrl

//--- tb/spe_ctrl_sva.sv
// Port checker for the EEPROM control block
`timescale 1ns/1ps
module spe_ctrl_sva #(
	parameter int WRITE_CYCLES = 50
) (
	// Clocks and reset
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic serialClk,
	// Link and status
	input wire logic chipSelN,
	input wire logic pauseN,
	input wire logic serialOut,
	input wire logic serialOutOe,
	input wire logic writeBusy
);
	logic [31:0] busyCnt;

	// ==========================================
	// Busy length counter
	always_ff @(posedge clk_sys) begin
		if (!resetn || !writeBusy)
			busyCnt <= 32'h0;
		else
			busyCnt <= busyCnt + 32'h1;
	end

	sequence busyRun;
		writeBusy [*8];
	endsequence

	desel_oe_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		chipSelN && $past(chipSelN) |-> !serialOutOe)
		else $error("output enabled while deselected");
	oe_drop_desel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(serialOutOe) |-> chipSelN)
		else $error("output enable dropped inside a frame");
	busy_after_desel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(writeBusy) |-> chipSelN && $past(chipSelN, 3))
		else $error("write cycle began while selected");
	busy_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(writeBusy) |-> busyRun)
		else $error("write cycle ended early");
	busy_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(writeBusy) |-> busyCnt >= WRITE_CYCLES - 1
			&& busyCnt <= WRITE_CYCLES + 1)
		else $error("write cycle length wrong");
	oe_selected_a: assert property (@(posedge serialClk) disable iff (!resetn)
		serialOutOe |-> !chipSelN)
		else $error("output enabled on clock without select");
	pause_out_a: assert property (@(negedge serialClk) disable iff (!resetn)
		!pauseN && $past(!pauseN) |-> $stable(serialOut))
		else $error("output moved during pause");
	pause_oe_a: assert property (@(negedge serialClk) disable iff (!resetn)
		!pauseN && $past(!pauseN) |-> $stable(serialOutOe))
		else $error("output enable moved during pause");
endmodule // spe_ctrl_sva

bind spe_eeprom_ctrl spe_ctrl_sva #(.WRITE_CYCLES(WRITE_CYCLES)) spe_ctrl_sva_inst (
	.clk_sys(clk_sys), .resetn(resetn), .serialClk(serialClk),
	.chipSelN(chipSelN), .pauseN(pauseN), .serialOut(serialOut),
	.serialOutOe(serialOutOe), .writeBusy(writeBusy));

//--- tb/spe_host_model.sv
// Serial host model: mode 0 master with pause support
`timescale 1ns/1ps
module spe_host_model (
	// Link towards the device
	output logic serialClk,
	output logic chipSelN,
	output logic serialIn,
	output logic pauseN,
	input  wire logic serialOut,
	input  wire logic serialOutOe
);
	// Clock idles low, select starts high
	initial begin
		serialClk = 1'b0;
		chipSelN = 1'b1;
		serialIn = 1'b0;
		pauseN = 1'b1;
	end

	// Select moves only with the clock low; long gap after release
	task automatic sel(input logic v);
		#30 chipSelN = v;
		#(v ? 300 : 30);
	endtask

	// One byte MSB first; pause before bit pz; undriven line reads as the previous bit inverted
	task automatic xbyte(input logic [7:0] d, input int pz,
		output logic [7:0] q);
		q = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			if (i == pz) begin
				#5 pauseN = 1'b0;
				repeat (3) begin
					serialIn = ~serialIn;
					#10 serialClk = 1'b1;
					#15 serialClk = 1'b0;
					#5;
				end
				pauseN = 1'b1;
			end
			serialIn = d[i];
			#15 serialClk = 1'b1;
			q = {q[6:0], serialOutOe ? serialOut : ~q[0]};
			#15 serialClk = 1'b0;
		end
	endtask
endmodule // spe_host_model

//--- tb/tb.sv
// Testbench for the EEPROM command and protection block
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic writeProtN = 1'b1;
	logic [7:0] q;
	logic [15:0] rx = 16'h0;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	wire serialClk, chipSelN, serialIn, pauseN;
	wire serialOut, serialOutOe, writeBusy;

	always #12.5 clk_sys = ~clk_sys;

	spe_eeprom_ctrl #(.WRITE_CYCLES(50)) spe_eeprom_ctrl_inst (.clk_sys,
		.resetn, .serialClk, .chipSelN, .serialIn, .pauseN, .writeProtN,
		.serialOut, .serialOutOe, .writeBusy);
	spe_host_model spe_host_model_inst (.serialClk, .chipSelN, .serialIn,
		.pauseN, .serialOut, .serialOutOe);

	task automatic chk(input string nm, input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask

	// Whole frame of n bytes; last two received bytes kept
	task automatic frm(input logic [39:0] tx, input int n, input int pz = 8);
		spe_host_model_inst.sel(1'b0);
		for (int k = 0; k < n; k++) begin
			spe_host_model_inst.xbyte(tx[39-8*k -: 8], (k == n-1) ? pz : 8, q);
			rx = {rx[7:0], q};
		end
		spe_host_model_inst.sel(1'b1);
	endtask

	task automatic st(input logic [7:0] exp, input string nm, input int pz = 8);
		frm(40'h0500000000, 2, pz);
		chk(nm, rx[7:0], exp);
	endtask

	task automatic wen;
		frm(40'h0600000000, 1);
	endtask

	task automatic idle;
		for (int i = 0; i < 400 && writeBusy !== 1'b0; i++)
			@(negedge clk_sys);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	// Main sequence
	initial begin
		repeat (4) @(negedge clk_sys);
		resetn = 1'b1;
		repeat (12) @(negedge clk_sys);
		chk("busy_rst", {7'h0, writeBusy}, 8'h00);
		st(8'h00, "st_rst");
		frm(40'h0200005500, 4);
		repeat (20) @(negedge clk_sys);
		chk("busy_nolatch", {7'h0, writeBusy}, 8'h00);
		wen();
		st(8'h02, "st_set");
		frm(40'h0400000000, 1);
		st(8'h00, "st_clr");
		frm(40'h0600000000, 2);
		st(8'h00, "st_noframe");
		wen();
		frm(40'h02001FA1B2, 5);
		chk("busy_on", {7'h0, writeBusy}, 8'h01);
		st(8'hFF, "st_busy");
		idle();
		st(8'h00, "st_done");
		wen();
		frm(40'h021FFFC3D4, 5);
		idle();
		frm(40'h031FFF0000, 5);
		chk("rd_top", rx[15:8], 8'hC3);
		chk("rd_wrap", rx[7:0], 8'hB2);
		frm(40'h031FE00000, 4);
		chk("pg_wrap", rx[7:0], 8'hD4);
		frm(40'h03001F0000, 4);
		chk("rd_first", rx[7:0], 8'hA1);
		frm(40'hAA55000000, 2);
		chk("unk_op", rx[7:0], 8'hAA);
		wen();
		frm(40'h018F000000, 2);
		idle();
		st(8'h8C, "st_write_status_cmd");
		st(8'h8C, "st_pause", 3);
		wen();
		frm(40'h0200005500, 4);
		idle();
		frm(40'h0300000000, 4);
		chk("guard_all", rx[7:0], 8'hB2);
		@(negedge clk_sys) writeProtN = 1'b0;
		wen();
		frm(40'h0100000000, 2);
		idle();
		st(8'h8E, "st_hwp");
		@(negedge clk_sys) writeProtN = 1'b1;
		spe_host_model_inst.sel(1'b0);
		spe_host_model_inst.xbyte(8'h01, 8, q);
		@(negedge clk_sys) writeProtN = 1'b0;
		spe_host_model_inst.xbyte(8'h00, 8, q);
		// Pin back high before select rises: only the abort can refuse
		@(negedge clk_sys) writeProtN = 1'b1;
		spe_host_model_inst.sel(1'b1);
		idle();
		st(8'h8E, "st_wp_abort");
		frm(40'h0100000000, 2);
		idle();
		@(negedge clk_sys) writeProtN = 1'b0;
		wen();
		frm(40'h0104000000, 2);
		idle();
		st(8'h04, "st_pin_off");
		wen();
		frm(40'h021FFF1100, 4);
		idle();
		frm(40'h031FFF0000, 4);
		chk("guard_qtr", rx[7:0], 8'hC3);
		end_sim();
	end
endmodule // tb
